//--- ssv_defines.vh
// constants of the supply supervisor low-power control block
`ifndef SSV_DEFINES_VH
`define SSV_DEFINES_VH

// register byte addresses (word aligned)
`define SSV_OFS_LOW_CTL     4'h0
`define SSV_OFS_HIGH_CTL    4'h4
`define SSV_OFS_FLAG        4'h8
`define SSV_OFS_MASK        4'hc

// low_side_supervisor_control fields
`define SSV_L_SVS_EN        0
`define SSV_L_SVS_MD        1
`define SSV_L_SVS_FP        2
`define SSV_L_MON_EN        3
`define SSV_L_MON_FP        4
`define SSV_L_AUTO          5
`define SSV_L_EVT_RESET     6
`define SSV_L_WIDTH         7

// high_side_supervisor_control fields
`define SSV_H_SVS_EN        0
`define SSV_H_SVS_MD        1
`define SSV_H_SVS_FP        2
`define SSV_H_MON_EN        3
`define SSV_H_MON_FP        4
`define SSV_H_AUTO          5
`define SSV_H_OVP_EN        6
`define SSV_H_WIDTH         7

// reset values: low side enabled in normal performance, high side off
`define SSV_L_RESET         7'h0b
`define SSV_H_RESET         7'h00

// power_manager_flag_register fields
`define SSV_F_L_DLY         0
`define SSV_F_H_DLY         1
`define SSV_F_L_SVS_EVT     2
`define SSV_F_L_MON_EVT     3
`define SSV_F_H_SVS_EVT     4
`define SSV_F_H_MON_EVT     5
`define SSV_F_WIDTH         6
`define SSV_EVT_MASK_RESET  6'h00

// settle times in ns and clock period
`define SSV_CLK_NS          20
`define SSV_SETTLE_FULL_NS  2000
`define SSV_SETTLE_NORM_NS  150000

// unit states
`define SSV_UNIT_OFF        2'h0
`define SSV_UNIT_NORMAL     2'h1
`define SSV_UNIT_FULL       2'h2

`endif

//--- ssv_settle_timer.v
// settling-delay counter for one supervisor side
`timescale 1ns/1ns
`include "ssv_defines.vh"

module ssv_settle_timer #(
    parameter [15:0] P_NORM_CYC = 16'd7500,
    parameter [15:0] P_FULL_CYC = 16'd100
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire        i_start,
    input  wire        i_full_perf,
    output reg         o_busy
);
    reg [15:0] cnt_q;

    // load on a control write, count down, busy while nonzero
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= 16'h0000;
            o_busy <= 1'b0;
        end else if (i_start) begin
            cnt_q  <= i_full_perf ? P_FULL_CYC : P_NORM_CYC;
            o_busy <= 1'b1;
        end else if (cnt_q > 16'h0001) begin
            cnt_q  <= cnt_q - 16'h0001;
        end else begin
            cnt_q  <= 16'h0000;
            o_busy <= 1'b0;
        end
    end
endmodule

//--- ssv_supervisor_ctrl.v
// supply supervisor and monitor low-power control with avalon-mm registers
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "ssv_defines.vh"

module ssv_supervisor_ctrl (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire        i_soft_power_up_clear,
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    input  wire [3:0]  i_avs_byteenable,
    input  wire [1:0]  i_sleep_level_req,
    input  wire        i_sleep_enter,
    input  wire        i_wake_event,
    input  wire        i_core_supervisor_trip,
    input  wire        i_core_monitor_trip,
    input  wire        i_io_supervisor_trip,
    input  wire        i_io_monitor_trip,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest,
    output reg         o_deep_sleep,
    output reg         o_wake_slow,
    output reg         o_wake_done,
    output reg  [1:0]  o_core_supervisor_state,
    output reg  [1:0]  o_core_monitor_state,
    output reg  [1:0]  o_io_supervisor_state,
    output reg  [1:0]  o_io_monitor_state,
    output reg         o_por_req,
    output reg         o_irq
);
    // settle counts in clock cycles, cut to the counter width on purpose
    localparam integer FULL_NUM = `SSV_SETTLE_FULL_NS / `SSV_CLK_NS;
    localparam integer NORM_NUM = `SSV_SETTLE_NORM_NS / `SSV_CLK_NS;
    localparam [15:0]  FULL_CYC = FULL_NUM[15:0];
    localparam [15:0]  NORM_CYC = NORM_NUM[15:0];
    localparam [15:0] WAKE_CYC_SLOW = NORM_CYC;
    localparam [15:0] WAKE_CYC_FAST = FULL_CYC;

    // sleep sequencer, one-hot
    localparam [2:0] ST_RUN   = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_WAKE  = 3'b100;

    reg [`SSV_L_WIDTH-1:0] low_ctl_q;
    reg [`SSV_H_WIDTH-1:0] high_ctl_q;
    reg [`SSV_F_WIDTH-1:0] flag_q;
    reg [`SSV_F_WIDTH-1:0] mask_q;
    reg [2:0]              state_q;
    reg [2:0]              state_d;
    reg [15:0]             wake_cnt_q;
    reg                    ack_q;
    reg                    deep_q;

    wire access   = (i_avs_read | i_avs_write) & ~ack_q;
    wire wr       = i_avs_write & ack_q & i_avs_byteenable[0]; // lands at the answer edge
    wire wr_low   = wr & (i_avs_address == `SSV_OFS_LOW_CTL);
    wire wr_high  = wr & (i_avs_address == `SSV_OFS_HIGH_CTL);
    wire wr_flag  = wr & (i_avs_address == `SSV_OFS_FLAG);
    wire wr_mask  = wr & (i_avs_address == `SSV_OFS_MASK);
    wire low_busy;
    wire high_busy;

    // unit state from enable, mode bit, full perf, auto control and sleep depth
    function [1:0] unit_state;
        input en;
        input md;
        input fp;
        input auto_ctl;
        input deep;
        begin
            if (!en) begin
                unit_state = `SSV_UNIT_OFF;
            end else if (!deep) begin
                unit_state = fp ? `SSV_UNIT_FULL : `SSV_UNIT_NORMAL;
            end else if (!md) begin
                unit_state = `SSV_UNIT_OFF;
            end else if (!auto_ctl) begin
                unit_state = fp ? `SSV_UNIT_FULL : `SSV_UNIT_NORMAL;
            end else begin
                unit_state = fp ? `SSV_UNIT_NORMAL : `SSV_UNIT_OFF;
            end
        end
    endfunction

    // slow wakeup whenever a low-side unit is enabled in normal performance
    wire slow_wake = (low_ctl_q[`SSV_L_SVS_EN] & ~low_ctl_q[`SSV_L_SVS_FP]) |
                     (low_ctl_q[`SSV_L_MON_EN] & ~low_ctl_q[`SSV_L_MON_FP]);

    // current unit states, monitors always treated as mode bit set
    wire [1:0] core_sup_st = unit_state(low_ctl_q[`SSV_L_SVS_EN], low_ctl_q[`SSV_L_SVS_MD],
                                        low_ctl_q[`SSV_L_SVS_FP], low_ctl_q[`SSV_L_AUTO], deep_q);
    wire [1:0] core_mon_st = unit_state(low_ctl_q[`SSV_L_MON_EN], 1'b1,
                                        low_ctl_q[`SSV_L_MON_FP], low_ctl_q[`SSV_L_AUTO], deep_q);
    wire [1:0] io_sup_st   = unit_state(high_ctl_q[`SSV_H_SVS_EN], high_ctl_q[`SSV_H_SVS_MD],
                                        high_ctl_q[`SSV_H_SVS_FP], high_ctl_q[`SSV_H_AUTO],
                                        deep_q);
    // auto control: high-side monitor inactive in deep sleep regardless of full perf
    wire [1:0] io_mon_raw  = unit_state(high_ctl_q[`SSV_H_MON_EN], 1'b1,
                                        high_ctl_q[`SSV_H_MON_FP], high_ctl_q[`SSV_H_AUTO],
                                        deep_q);
    wire [1:0] io_mon_st   = (deep_q & high_ctl_q[`SSV_H_AUTO]) ? `SSV_UNIT_OFF : io_mon_raw;

    // trips count only while the unit is active
    wire [`SSV_F_WIDTH-1:0] evt;
    assign evt[`SSV_F_L_DLY]     = 1'b0;
    assign evt[`SSV_F_H_DLY]     = 1'b0;
    assign evt[`SSV_F_L_SVS_EVT] = i_core_supervisor_trip & (core_sup_st != `SSV_UNIT_OFF);
    assign evt[`SSV_F_L_MON_EVT] = i_core_monitor_trip & (core_mon_st != `SSV_UNIT_OFF);
    assign evt[`SSV_F_H_SVS_EVT] = i_io_supervisor_trip & (io_sup_st != `SSV_UNIT_OFF);
    assign evt[`SSV_F_H_MON_EVT] = i_io_monitor_trip & (io_mon_st != `SSV_UNIT_OFF);

    wire low_evt = evt[`SSV_F_L_SVS_EVT] | evt[`SSV_F_L_MON_EVT];
    // routes a trip to power-on reset
    wire por_d = (low_evt & low_ctl_q[`SSV_L_EVT_RESET]) |
                 evt[`SSV_F_H_SVS_EVT] |
                 (evt[`SSV_F_H_MON_EVT] & high_ctl_q[`SSV_H_OVP_EN]);

    // settle timers, restarted on each control write
    ssv_settle_timer #(
        .P_NORM_CYC (NORM_CYC),
        .P_FULL_CYC (FULL_CYC)
    ) u_low_settle (
        .i_ref_clk   (i_ref_clk),
        .i_rst_b     (i_rst_b),
        .i_start     (wr_low),
        .i_full_perf (i_avs_writedata[`SSV_L_SVS_FP]),
        .o_busy      (low_busy)
    );

    ssv_settle_timer #(
        .P_NORM_CYC (NORM_CYC),
        .P_FULL_CYC (FULL_CYC)
    ) u_high_settle (
        .i_ref_clk   (i_ref_clk),
        .i_rst_b     (i_rst_b),
        .i_start     (wr_high),
        .i_full_perf (i_avs_writedata[`SSV_H_SVS_FP]),
        .o_busy      (high_busy)
    );

    // sequencer next state; deep sleep refused while settling
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (i_sleep_enter && (i_sleep_level_req != 2'h0) && !low_busy && !high_busy) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (i_wake_event) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_q == 16'h0001) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
        if (i_soft_power_up_clear) begin
            state_d = ST_RUN;
        end
    end

    // sequencer registers and wakeup timer
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q    <= ST_RUN;
            wake_cnt_q <= 16'h0000;
            deep_q     <= 1'b0;
        end else begin
            state_q <= state_d;
            deep_q  <= state_d[1];
            if (state_q[1] && state_d[2]) begin
                wake_cnt_q <= slow_wake ? WAKE_CYC_SLOW : WAKE_CYC_FAST;
            end else if (wake_cnt_q != 16'h0000) begin
                wake_cnt_q <= wake_cnt_q - 16'h0001;
            end
        end
    end

    // control, flag and mask registers
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_ctl_q  <= `SSV_L_RESET;
            high_ctl_q <= `SSV_H_RESET;
            flag_q     <= {`SSV_F_WIDTH{1'b0}};
            mask_q     <= `SSV_EVT_MASK_RESET;
        end else begin
            if (i_soft_power_up_clear) begin
                low_ctl_q  <= `SSV_L_RESET;
                high_ctl_q <= `SSV_H_RESET;
                mask_q     <= `SSV_EVT_MASK_RESET;
            end else begin
                if (wr_low) begin
                    low_ctl_q <= i_avs_writedata[`SSV_L_WIDTH-1:0];
                end
                if (wr_high) begin
                    high_ctl_q <= i_avs_writedata[`SSV_H_WIDTH-1:0];
                end
                if (wr_mask) begin
                    mask_q <= i_avs_writedata[`SSV_F_WIDTH-1:0];
                end
            end
            // sticky events: set beats write-one-to-clear
            flag_q[`SSV_F_L_DLY] <= low_busy;
            flag_q[`SSV_F_H_DLY] <= high_busy;
            flag_q[`SSV_F_WIDTH-1:2] <= evt[`SSV_F_WIDTH-1:2] |
                (flag_q[`SSV_F_WIDTH-1:2] &
                 ~({(`SSV_F_WIDTH-2){wr_flag}} & i_avs_writedata[`SSV_F_WIDTH-1:2]));
        end
    end

    // avalon slave: one wait cycle, then answer; unmapped reads zero
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q             <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            ack_q             <= access;
            o_avs_waitrequest <= ~access;
            o_avs_readdata    <= 32'h0000_0000;
            if (access && i_avs_read) begin
                case (i_avs_address)
                    `SSV_OFS_LOW_CTL:  o_avs_readdata[`SSV_L_WIDTH-1:0] <= low_ctl_q;
                    `SSV_OFS_HIGH_CTL: o_avs_readdata[`SSV_H_WIDTH-1:0] <= high_ctl_q;
                    `SSV_OFS_FLAG:     o_avs_readdata[`SSV_F_WIDTH-1:0] <= flag_q;
                    `SSV_OFS_MASK:     o_avs_readdata[`SSV_F_WIDTH-1:0] <= mask_q;
                    default:           o_avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // registered outputs
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_deep_sleep            <= 1'b0;
            o_wake_slow             <= 1'b1;
            o_wake_done             <= 1'b0;
            o_core_supervisor_state <= `SSV_UNIT_NORMAL; // matches the reset control word
            o_core_monitor_state    <= `SSV_UNIT_NORMAL;
            o_io_supervisor_state   <= `SSV_UNIT_OFF;
            o_io_monitor_state      <= `SSV_UNIT_OFF;
            o_por_req               <= 1'b0;
            o_irq                   <= 1'b0;
        end else begin
            o_deep_sleep            <= deep_q;
            o_wake_slow             <= slow_wake;
            o_wake_done             <= state_q[2] & state_d[0];
            o_core_supervisor_state <= core_sup_st;
            o_core_monitor_state    <= core_mon_st;
            o_io_supervisor_state   <= io_sup_st;
            o_io_monitor_state      <= io_mon_st;
            o_por_req               <= por_d;
            o_irq                   <= |(flag_q[`SSV_F_WIDTH-1:2] & mask_q[`SSV_F_WIDTH-1:2]);
        end
    end
endmodule

//--- ssv_supervisor_chk.sv
// port checks for the supervisor low-power control block
`timescale 1ns/1ns
`include "ssv_defines.vh"

module ssv_supervisor_chk (
    input wire        i_ref_clk,
    input wire        i_rst_b,
    input wire        i_soft_power_up_clear,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [1:0]  i_sleep_level_req,
    input wire        i_sleep_enter,
    input wire        i_wake_event,
    input wire        i_core_supervisor_trip,
    input wire        i_core_monitor_trip,
    input wire        i_io_supervisor_trip,
    input wire        i_io_monitor_trip,
    input wire        o_avs_waitrequest,
    input wire        o_deep_sleep,
    input wire        o_wake_slow,
    input wire        o_wake_done,
    input wire [1:0]  o_core_supervisor_state,
    input wire [1:0]  o_core_monitor_state,
    input wire        o_por_req,
    input wire        o_irq
);
    wire trip_any;
    wire core_norm;
    // any trip input, and a low-side unit running in normal performance
    assign trip_any = i_core_supervisor_trip | i_core_monitor_trip | i_io_supervisor_trip
                    | i_io_monitor_trip;
    assign core_norm = (o_core_supervisor_state == `SSV_UNIT_NORMAL)
                     | (o_core_monitor_state == `SSV_UNIT_NORMAL);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // bus answer one cycle after the request is taken, one cycle long
    bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered next cycle");
    answer_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    // wakeup speed follows the low-side performance
    slow_wake_a: assert property (!o_deep_sleep && core_norm |-> ##[0:2] o_wake_slow)
        else $error("normal low-side unit without slow wakeup");
    fast_wake_a: assert property (!o_deep_sleep && !core_norm |-> ##[0:2] !o_wake_slow)
        else $error("slow wakeup without normal low-side unit");
    fast_done_a: assert property (o_deep_sleep && i_wake_event && !o_wake_slow
        |-> ##[90:110] o_wake_done) else $error("fast wakeup not done in time");
    slow_hold_a: assert property (o_deep_sleep && i_wake_event && o_wake_slow
        |=> !o_wake_done [*8]) else $error("slow wakeup done too early");
    done_pulse_a: assert property (o_wake_done |=> !o_wake_done)
        else $error("wake done longer than one cycle");
    por_cause_a: assert property (o_por_req |-> trip_any || $past(trip_any))
        else $error("reset request without a trip");
    refuse_light_a: assert property (!$past(i_sleep_enter) && i_sleep_enter
        && i_sleep_level_req == 2'h0 && !o_deep_sleep |=> !o_deep_sleep)
        else $error("light sleep request entered deep sleep");
    clear_run_a: assert property (i_soft_power_up_clear |-> ##[1:2] !o_deep_sleep)
        else $error("soft clear left deep sleep");
    cover property (o_wake_done);
    cover property (o_por_req);
    cover property (o_irq);
endmodule

bind ssv_supervisor_ctrl ssv_supervisor_chk u_chk (.*);

//--- tb.sv
// self-checking bench for the supervisor low-power control block
`timescale 1ns/1ns
`include "ssv_defines.vh"

module tb;
    reg         i_ref_clk, i_rst_b, i_soft_power_up_clear, i_avs_read, i_avs_write;
    reg  [3:0]  i_avs_address, i_avs_byteenable;
    reg  [31:0] i_avs_writedata;
    reg  [1:0]  i_sleep_level_req;
    reg         i_sleep_enter, i_wake_event, i_core_supervisor_trip, i_core_monitor_trip;
    reg         i_io_supervisor_trip, i_io_monitor_trip;
    wire [31:0] o_avs_readdata;
    wire        o_avs_waitrequest, o_deep_sleep, o_wake_slow, o_wake_done, o_por_req, o_irq;
    wire [1:0]  o_core_supervisor_state, o_core_monitor_state;
    wire [1:0]  o_io_supervisor_state, o_io_monitor_state;
    integer     mismatches, samples_checked, n;
    reg  [31:0] rdat;

    ssv_supervisor_ctrl DUT (.*);

    // 50 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    // compare a value, and a count against a range
    task chk(input [8*12-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task chk_range(input [8*12-1:0] nm, input integer lo, input integer hi, input integer g);
        begin
            samples_checked = samples_checked + 1;
            if (g < lo || g > hi) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %0d..%0d seen %0d", nm, lo, hi, g);
            end
        end
    endtask

    // avalon-mm transfer held until waitrequest is sampled low
    task bus(input we, input [3:0] a, input [31:0] d);
        begin
            @(posedge i_ref_clk);
            i_avs_address <= a;
            i_avs_writedata <= d;
            i_avs_write <= we;
            i_avs_read <= ~we;
            @(posedge i_ref_clk);
            while (o_avs_waitrequest !== 1'b0) begin
                @(posedge i_ref_clk);
            end
            rdat = o_avs_readdata;
            i_avs_write <= 1'b0;
            i_avs_read <= 1'b0;
        end
    endtask
    task rdc(input [8*12-1:0] nm, input [3:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk(nm, e, rdat);
        end
    endtask

    // poll both settle flags until clear, n counts the polls
    task settle;
        begin
            n = 0;
            rdat = 32'h3;
            while (rdat[1:0] !== 2'h0 && n < 4000) begin
                bus(1'b0, `SSV_OFS_FLAG, 32'h0);
                n = n + 1;
            end
        end
    endtask

    // sleep entry request, then wakeup timed in cycles
    task enter(input [1:0] lvl);
        begin
            @(posedge i_ref_clk);
            i_sleep_level_req <= lvl;
            i_sleep_enter <= 1'b1;
            @(posedge i_ref_clk);
            i_sleep_enter <= 1'b0;
            repeat (3) @(posedge i_ref_clk);
        end
    endtask
    task wake(input integer lo, input integer hi);
        begin
            i_wake_event <= 1'b1;
            @(posedge i_ref_clk);
            i_wake_event <= 1'b0;
            n = 0;
            while (o_wake_done !== 1'b1 && n < 9000) begin
                @(posedge i_ref_clk);
                n = n + 1;
            end
            chk_range("wake_cycles", lo, hi, n);
            repeat (2) @(posedge i_ref_clk);
        end
    endtask
    task trip(input [3:0] t, input integer c);
        begin
            {i_io_monitor_trip, i_io_supervisor_trip, i_core_monitor_trip,
             i_core_supervisor_trip} <= t;
            repeat (c) @(posedge i_ref_clk);
        end
    endtask

    // verdict and end of run
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // watchdog on the whole run
    initial begin
        #1600000;
        mismatches = mismatches + 1;
        complete_run;
    end

    // test sequence
    initial begin
        mismatches = 0; samples_checked = 0; n = 0; rdat = 32'h0;
        i_rst_b = 1'b0; i_soft_power_up_clear = 1'b0; i_avs_read = 1'b0; i_avs_write = 1'b0;
        i_avs_address = 4'h0; i_avs_byteenable = 4'hf; i_avs_writedata = 32'h0;
        i_sleep_level_req = 2'h0; i_sleep_enter = 1'b0; i_wake_event = 1'b0;
        {i_io_monitor_trip, i_io_supervisor_trip, i_core_monitor_trip,
         i_core_supervisor_trip} = 4'h0;
        repeat (8) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        chk("wake_slow", 1, o_wake_slow);
        chk("core_sup", `SSV_UNIT_NORMAL, o_core_supervisor_state);
        chk("io_sup", `SSV_UNIT_OFF, o_io_supervisor_state);
        rdc("low_ctl", `SSV_OFS_LOW_CTL, 32'h0b);
        rdc("high_ctl", `SSV_OFS_HIGH_CTL, 32'h0);
        rdc("mask", `SSV_OFS_MASK, 32'h0);
        rdc("unmapped", 4'h2, 32'h0);
        i_avs_byteenable <= 4'he;
        bus(1'b1, `SSV_OFS_LOW_CTL, 32'h1d);
        i_avs_byteenable <= 4'hf;
        rdc("low_ctl_be", `SSV_OFS_LOW_CTL, 32'h0b);
        bus(1'b1, `SSV_OFS_LOW_CTL, 32'h1d);
        rdc("low_dly", `SSV_OFS_FLAG, 32'h1);
        settle;
        chk_range("settle_full", 20, 40, n);
        chk("core_sup", `SSV_UNIT_FULL, o_core_supervisor_state);
        chk("core_mon", `SSV_UNIT_FULL, o_core_monitor_state);
        chk("wake_slow", 0, o_wake_slow);
        bus(1'b1, `SSV_OFS_HIGH_CTL, 32'h29);
        enter(2'h3);
        chk("deep_settle", 0, o_deep_sleep);
        settle;
        chk_range("settle_norm", 2400, 2600, n);
        chk("io_sup", `SSV_UNIT_NORMAL, o_io_supervisor_state);
        chk("io_mon", `SSV_UNIT_NORMAL, o_io_monitor_state);
        enter(2'h0);
        chk("deep_light", 0, o_deep_sleep);
        enter(2'h3);
        chk("deep", 1, o_deep_sleep);
        chk("core_sup_d", `SSV_UNIT_OFF, o_core_supervisor_state);
        chk("core_mon_d", `SSV_UNIT_FULL, o_core_monitor_state);
        chk("io_sup_d", `SSV_UNIT_OFF, o_io_supervisor_state);
        chk("io_mon_d", `SSV_UNIT_OFF, o_io_monitor_state);
        wake(95, 110);
        repeat (7500) @(posedge i_ref_clk);
        chk("deep_hold", 0, o_deep_sleep);
        chk("io_sup_w", `SSV_UNIT_NORMAL, o_io_supervisor_state);
        bus(1'b1, `SSV_OFS_LOW_CTL, 32'h0b);
        settle;
        chk("wake_slow", 1, o_wake_slow);
        enter(2'h2);
        chk("core_mon_d", `SSV_UNIT_NORMAL, o_core_monitor_state);
        wake(7400, 7600);
        bus(1'b1, `SSV_OFS_MASK, 32'h3c);
        trip(4'h1, 1);
        trip(4'h0, 2);
        chk("irq", 1, o_irq);
        rdc("flag_sup", `SSV_OFS_FLAG, 32'h04);
        bus(1'b1, `SSV_OFS_FLAG, 32'h04);
        repeat (2) @(posedge i_ref_clk);
        chk("irq_clr", 0, o_irq);
        bus(1'b1, `SSV_OFS_MASK, 32'h0);
        trip(4'h2, 1);
        trip(4'h0, 2);
        rdc("flag_mon", `SSV_OFS_FLAG, 32'h08);
        chk("irq_mask", 0, o_irq);
        bus(1'b1, `SSV_OFS_LOW_CTL, 32'h4b);
        settle;
        trip(4'h1, 3);
        chk("por_low", 1, o_por_req);
        trip(4'h0, 3);
        chk("por_off", 0, o_por_req);
        bus(1'b1, `SSV_OFS_HIGH_CTL, 32'h48);
        settle;
        trip(4'h8, 3);
        chk("por_ovp", 1, o_por_req);
        trip(4'h0, 3);
        bus(1'b1, `SSV_OFS_HIGH_CTL, 32'h0f);
        settle;
        enter(2'h3);
        chk("io_sup_man", `SSV_UNIT_FULL, o_io_supervisor_state);
        chk("io_mon_man", `SSV_UNIT_NORMAL, o_io_monitor_state);
        i_soft_power_up_clear <= 1'b1;
        @(posedge i_ref_clk);
        i_soft_power_up_clear <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk("deep_clr", 0, o_deep_sleep);
        rdc("low_clr", `SSV_OFS_LOW_CTL, 32'h0b);
        rdc("high_clr", `SSV_OFS_HIGH_CTL, 32'h0);
        complete_run;
    end
endmodule
